// [pkg/mao_pkg.sv]
// Shared constants and types for the move/OR instruction execute block.
// Assumes a 14-bit instruction word and an 8-bit data path.
package mao_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int INSTR_W = 14;
  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 7;

  // ************************************************************
  // Field positions inside the instruction word
  // ************************************************************
  localparam int DEST_BIT  = 7;
  localparam int ADDR_MSB  = 6;
  localparam int LIT_MSB   = 7;
  localparam int OP6_LSB   = 8;
  localparam int OP7_LSB   = 7;
  localparam int OP4_LSB   = 10;

  // ************************************************************
  // Opcode patterns
  // ************************************************************
  localparam logic [5:0] OP_OR_ACC_FILE  = 6'h04;
  localparam logic [5:0] OP_MOVE_FILE    = 6'h08;
  localparam logic [6:0] OP_STORE_ACC    = 7'h01;
  localparam logic [3:0] OP_LOAD_LITERAL = 4'hc;

  // Destination select values
  localparam logic DEST_ACCUM = 1'b0;
  localparam logic DEST_FILE  = 1'b1;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [DATA_W-1:0] ACCUM_RESET = 8'h00;
  localparam logic              ZERO_RESET  = 1'b0;
  localparam logic [DATA_W-1:0] DATA_ZERO   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ZERO   = 7'h00;

  typedef enum logic [2:0]
  {
    MAO_OP_NONE,
    MAO_OP_OR_ACCUMULATOR_WITH_FILE,
    MAO_OP_MOVE_FILE_REGISTER,
    MAO_OP_STORE_ACCUMULATOR_TO_FILE,
    MAO_OP_LOAD_LITERAL_TO_ACCUMULATOR
  } mao_op_t;

endpackage

// [pkg/mao_dec_if.sv]
// Decoded instruction fields passed from the decoder to the execute stage.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
interface mao_dec_if;
  logic [mao_pkg::INSTR_W-1:0] instr;
  mao_pkg::mao_op_t            op;
  logic                        dest;
  logic [mao_pkg::ADDR_W-1:0]  addr;
  logic [mao_pkg::DATA_W-1:0]  literal;

  modport decoder (input instr, output op, output dest, output addr, output literal);
  modport exec    (output instr, input op, input dest, input addr, input literal);
endinterface

// [design/mao_decode.sv]
// Combinational decoder for the four supported instruction words.
// Assumes the instruction word is stable for the cycle it is presented.
`timescale 1ns/1ps
module mao_decode
(
  mao_dec_if.decoder dec
);

  // ************************************************************
  // Opcode match
  // ************************************************************
  always_comb
  begin
    if (dec.instr[mao_pkg::INSTR_W-1:mao_pkg::OP6_LSB] == mao_pkg::OP_OR_ACC_FILE)
      dec.op = mao_pkg::MAO_OP_OR_ACCUMULATOR_WITH_FILE;
    else if (dec.instr[mao_pkg::INSTR_W-1:mao_pkg::OP6_LSB] == mao_pkg::OP_MOVE_FILE)
      dec.op = mao_pkg::MAO_OP_MOVE_FILE_REGISTER;
    else if (dec.instr[mao_pkg::INSTR_W-1:mao_pkg::OP7_LSB] == mao_pkg::OP_STORE_ACC)
      dec.op = mao_pkg::MAO_OP_STORE_ACCUMULATOR_TO_FILE;
    // Bits 9:8 are don't-care for the literal load
    else if (dec.instr[mao_pkg::INSTR_W-1:mao_pkg::OP4_LSB] == mao_pkg::OP_LOAD_LITERAL)
      dec.op = mao_pkg::MAO_OP_LOAD_LITERAL_TO_ACCUMULATOR;
    else
      dec.op = mao_pkg::MAO_OP_NONE;
  end

  // ************************************************************
  // Operand fields
  // ************************************************************
  assign dec.dest    = dec.instr[mao_pkg::DEST_BIT];
  assign dec.addr    = dec.instr[mao_pkg::ADDR_MSB:0];
  assign dec.literal = dec.instr[mao_pkg::LIT_MSB:0];

endmodule

// [design/mao_exec.sv]
// Execute stage for four single-word data-move and OR instructions.
// Assumes the file register array is outside: it answers o_file_raddr with
// i_file_rdata in the same cycle and stores o_file_wdata when o_file_we is high.
// Assumes i_instr_valid is judged on every edge; the stage never stalls.
// Assumes the caller holds i_instr steady through the cycle it is valid.
`timescale 1ns/1ps
module mao_exec
(
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_sys_rst,
  // Instruction word
  input  wire logic                        i_instr_valid,
  input  wire logic [mao_pkg::INSTR_W-1:0] i_instr,
  // File register array
  input  wire logic [mao_pkg::DATA_W-1:0]  i_file_rdata,
  output logic      [mao_pkg::ADDR_W-1:0]  o_file_raddr,
  output logic                             o_file_we,
  output logic      [mao_pkg::ADDR_W-1:0]  o_file_waddr,
  output logic      [mao_pkg::DATA_W-1:0]  o_file_wdata,
  // Working state
  output logic      [mao_pkg::DATA_W-1:0]  o_accum,
  output logic                             o_zero,
  // Retire pulses
  output logic                             o_done,
  output logic                             o_unsupported
);

  // ************************************************************
  // Decode
  // ************************************************************
  mao_dec_if dec ();

  assign dec.instr = i_instr;

  mao_decode u_decode
  (
    .dec (dec)
  );

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic is_zero(input logic [mao_pkg::DATA_W-1:0] v);
    is_zero = (v == mao_pkg::DATA_ZERO);
  endfunction

  // Destination decode is shared by OR and move-file
  function automatic logic to_accum(input logic dest);
    to_accum = (dest == mao_pkg::DEST_ACCUM);
  endfunction

  function automatic logic to_file(input logic dest);
    to_file = (dest == mao_pkg::DEST_FILE);
  endfunction

  // ************************************************************
  // Operand fetch with write forwarding
  // ************************************************************
  // The file write lands one edge after the instruction that produced it, so a
  // back-to-back read of the same register would otherwise see the stale value.
  // Only the one write in flight is compared; older writes have already landed.
  logic [mao_pkg::DATA_W-1:0] file_operand;
  logic                       fwd_addr_match;
  logic                       fwd_hit;

  assign o_file_raddr   = dec.addr;
  assign fwd_addr_match = (o_file_waddr == dec.addr);
  assign fwd_hit        = o_file_we && fwd_addr_match;
  assign file_operand   = fwd_hit ? o_file_wdata : i_file_rdata;

  // ************************************************************
  // Per-instruction results
  // ************************************************************
  logic [mao_pkg::DATA_W-1:0] or_value;
  logic [mao_pkg::DATA_W-1:0] move_value;
  logic [mao_pkg::DATA_W-1:0] store_value;
  logic [mao_pkg::DATA_W-1:0] literal_value;

  assign or_value      = o_accum | file_operand;
  assign move_value    = file_operand;
  assign store_value   = o_accum;
  assign literal_value = dec.literal;

  // ************************************************************
  // Result and write-back selection
  // ************************************************************
  logic [mao_pkg::DATA_W-1:0] next_result;
  logic                       next_accum_we;
  logic                       next_file_we;
  logic                       next_zero_we;
  logic                       supported;

  always_comb
  begin
    next_result   = mao_pkg::DATA_ZERO;
    next_accum_we = 1'b0;
    next_file_we  = 1'b0;
    next_zero_we  = 1'b0;
    supported     = 1'b1;
    case (dec.op)
      mao_pkg::MAO_OP_OR_ACCUMULATOR_WITH_FILE:
      begin
        next_result   = or_value;
        next_zero_we  = 1'b1;
        next_accum_we = to_accum(dec.dest);
        next_file_we  = to_file(dec.dest);
      end
      mao_pkg::MAO_OP_MOVE_FILE_REGISTER:
      begin
        next_result   = move_value;
        next_accum_we = to_accum(dec.dest);
        // Rewriting the same value is harmless and keeps the file side uniform
        next_file_we  = to_file(dec.dest);
        next_zero_we  = 1'b1;
      end
      mao_pkg::MAO_OP_STORE_ACCUMULATOR_TO_FILE:
      begin
        next_result  = store_value;
        next_file_we = 1'b1;
      end
      mao_pkg::MAO_OP_LOAD_LITERAL_TO_ACCUMULATOR:
      begin
        next_result   = literal_value;
        next_accum_we = 1'b1;
      end
      // Any other word writes nothing and is reported as refused
      default:
      begin
        supported = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // Acceptance
  // ************************************************************
  // Enables are qualified once here so each state block sees a single strobe
  logic accum_wr;
  logic zero_wr;
  logic file_wr;

  assign accum_wr = i_instr_valid && next_accum_we;
  assign zero_wr  = i_instr_valid && next_zero_we;
  assign file_wr  = i_instr_valid && next_file_we;

  // ************************************************************
  // Accumulator
  // ************************************************************
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_accum <= mao_pkg::ACCUM_RESET;
    else if (accum_wr)
      o_accum <= next_result;
  end

  // ************************************************************
  // Zero flag
  // ************************************************************
  // Store and literal load never touch it; only OR and move-file write it.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_zero <= mao_pkg::ZERO_RESET;
    else if (zero_wr)
      o_zero <= is_zero(next_result);
  end

  // ************************************************************
  // File write-back
  // ************************************************************
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_file_we <= 1'b0;
    else
      o_file_we <= file_wr;
  end

  // Address and data load only with a write, so the forwarding compare sees the last one
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_file_waddr <= mao_pkg::ADDR_ZERO;
      o_file_wdata <= mao_pkg::DATA_ZERO;
    end
    else if (file_wr)
    begin
      o_file_waddr <= dec.addr;
      o_file_wdata <= next_result;
    end
  end

  // ************************************************************
  // Completion
  // ************************************************************
  // Every supported instruction retires in the cycle after it is taken; no stall exists.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_done <= 1'b0;
    else
      o_done <= i_instr_valid && supported;
  end

  // A refused word changes no state; this pulse is the only trace it leaves
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_unsupported <= 1'b0;
    else
      o_unsupported <= i_instr_valid && !supported;
  end

endmodule

// [testbench/mao_exec_asserts.sv]
// Port checks for the move/OR execute block.
// Assumes it is bound to the execute block and sees only its ports.
`timescale 1ns/1ps
module mao_exec_asserts
(
  input wire logic        i_ref_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_instr_valid,
  input wire logic [13:0] i_instr,
  input wire logic [7:0]  i_file_rdata,
  input wire logic [6:0]  o_file_raddr,
  input wire logic        o_file_we,
  input wire logic [6:0]  o_file_waddr,
  input wire logic [7:0]  o_file_wdata,
  input wire logic [7:0]  o_accum,
  input wire logic        o_zero,
  input wire logic        o_done
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // Forwarded cycles are left out: the read data is then replaced
  wire go  = i_instr_valid && !o_file_we;
  wire ior = go && i_instr[13:8] == 6'h04;
  wire mov = go && i_instr[13:8] == 6'h08;
  wire sto = go && i_instr[13:7] == 7'h01;
  wire lit = go && i_instr[13:10] == 4'hc;
  // ************************************************************
  // Assertions
  // ************************************************************
  read_addr_a: assert property (o_file_raddr == i_instr[6:0])
    else $error("read address wrong");
  or_accum_a: assert property (ior && !i_instr[7] |=>
    o_accum == ($past(o_accum) | $past(i_file_rdata)) && o_zero == (o_accum == 8'h00))
    else $error("OR to accumulator wrong");
  or_file_a: assert property (ior && i_instr[7] |=> o_file_we && $stable(o_accum) &&
    o_file_wdata == ($past(o_accum) | $past(i_file_rdata))) else $error("OR to file wrong");
  move_dest_a: assert property (mov |=> o_file_we == $past(i_instr[7]) &&
    (o_file_we ? o_file_wdata : o_accum) == $past(i_file_rdata))
    else $error("move result wrong");
  move_zero_a: assert property (mov |=> o_zero == ($past(i_file_rdata) == 8'h00))
    else $error("move zero flag wrong");
  store_write_a: assert property (sto |=> o_file_we && $stable(o_zero) &&
    o_file_waddr == $past(o_file_raddr) && o_file_wdata == $past(o_accum))
    else $error("store wrong");
  load_value_a: assert property (lit |=> o_accum == $past(i_instr[7:0]) &&
    $stable(o_zero) && !o_file_we) else $error("literal load wrong");
  // Back-to-back words keep o_done high, so the drop is checked on idle cycles
  one_cycle_a: assert property (ior || mov || sto || lit |=> o_done)
    else $error("done pulse missing");
  idle_quiet_a: assert property (!i_instr_valid |=> !o_done && !o_file_we)
    else $error("pulse without instruction");
  or_file_c: cover property (ior && i_instr[7]);
  move_zero_c: cover property (mov ##1 o_zero);
  store_c: cover property (sto);
  forward_c: cover property (i_instr_valid && o_file_we && o_file_waddr == o_file_raddr);
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the execute block.
// Assumes the bench stands in for the file array and answers reads at once.
`timescale 1ns/1ps
module testbench;
  logic        i_ref_clk, i_sys_rst, i_instr_valid, we, zero, done, unsup;
  logic [13:0] i_instr;
  logic [7:0]  i_file_rdata, wdata, acc;
  logic [6:0]  raddr, waddr;
  int          n_errors = 0;
  int          checks_done = 0;

  mao_exec mao_exec_inst (.i_ref_clk, .i_sys_rst, .i_instr_valid, .i_instr, .i_file_rdata,
    .o_file_raddr(raddr), .o_file_we(we), .o_file_waddr(waddr), .o_file_wdata(wdata),
    .o_accum(acc), .o_zero(zero), .o_done(done), .o_unsupported(unsup));
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One idle cycle between words keeps the write forwarding path out of play
  task automatic run(input logic [13:0] ins, input logic [7:0] rd);
    @(posedge i_ref_clk);
    i_instr <= ins;
    i_file_rdata <= rd;
    i_instr_valid <= 1'b1;
    @(posedge i_ref_clk);
    i_instr_valid <= 1'b0;
    i_file_rdata <= ~rd;
    @(negedge i_ref_clk);
  endtask
  task automatic see(input logic [7:0] a, input logic z, input logic w);
    chk(acc, a);
    chk(8'(zero), 8'(z));
    chk(8'(we), 8'(w));
  endtask
  task automatic seew(input logic [6:0] a, input logic [7:0] d);
    chk(8'(waddr), 8'(a));
    chk(wdata, d);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_or();
    run(14'h3091, 8'h00);
    run(14'h0413, 8'h13);
    see(8'h93, 1'b0, 1'b0);
    chk(8'(done), 8'h01);
    run(14'h0495, 8'h44);
    see(8'h93, 1'b0, 1'b1);
    seew(7'h15, 8'hd7);
    run(14'h3000, 8'h00);
    run(14'h0420, 8'h00);
    see(8'h00, 1'b1, 1'b0);
    $display("t_or finished");
  endtask
  task automatic t_load_move();
    run(14'h335a, 8'h00);
    see(8'h5a, 1'b1, 1'b0);
    run(14'h08aa, 8'h5c);
    see(8'h5a, 1'b0, 1'b1);
    seew(7'h2a, 8'h5c);
    run(14'h08aa, 8'h00);
    see(8'h5a, 1'b1, 1'b1);
    seew(7'h2a, 8'h00);
    run(14'h0811, 8'hc3);
    see(8'hc3, 1'b0, 1'b0);
    $display("t_load_move finished");
  endtask
  task automatic t_store();
    run(14'h08ff, 8'h00);
    run(14'h00ff, 8'h11);
    see(8'hc3, 1'b1, 1'b1);
    seew(7'h7f, 8'hc3);
    run(14'h3800, 8'h00);
    chk(8'({unsup, done}), 8'h02);
    see(8'hc3, 1'b1, 1'b0);
    $display("t_store finished");
  endtask
  // Back to back: the move reads the register the OR has not yet written
  task automatic t_fwd();
    run(14'h3021, 8'h00);
    @(posedge i_ref_clk);
    i_instr <= 14'h0495;
    i_file_rdata <= 8'h40;
    i_instr_valid <= 1'b1;
    @(posedge i_ref_clk);
    i_instr <= 14'h0815;
    i_file_rdata <= 8'h00;
    @(posedge i_ref_clk);
    i_instr_valid <= 1'b0;
    @(negedge i_ref_clk);
    see(8'h61, 1'b0, 1'b0);
    chk(8'(done), 8'h01);
    $display("t_fwd finished");
  endtask
  task automatic t_reset();
    @(posedge i_ref_clk);
    i_sys_rst <= 1'b1;
    @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    @(negedge i_ref_clk);
    see(8'h00, 1'b0, 1'b0);
    chk(8'({unsup, done}), 8'h00);
    run(14'h0415, 8'h00);
    see(8'h00, 1'b1, 1'b0);
    $display("t_reset finished");
  endtask
  // ************************************************************
  // Sequence
  // ************************************************************
  initial
  begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  initial
  begin
    #20000;
    n_errors++;
    end_sim();
  end
  initial
  begin
    i_sys_rst = 1'b1;
    i_instr_valid = 1'b0;
    i_instr = 14'h0000;
    i_file_rdata = 8'h00;
    repeat (12) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    @(negedge i_ref_clk);
    see(8'h00, 1'b0, 1'b0);
    t_or();
    t_load_move();
    t_store();
    t_fwd();
    t_reset();
    end_sim();
  end
endmodule
bind mao_exec mao_exec_asserts mao_exec_asserts_inst (.i_ref_clk, .i_sys_rst, .i_instr_valid,
  .i_instr, .i_file_rdata, .o_file_raddr, .o_file_we, .o_file_waddr, .o_file_wdata,
  .o_accum, .o_zero, .o_done);
